// file: hw/bsh_consts.svh
// Constants shared by both ends of the burst SRAM host interface.
// Contract
// - Low load strobe at clock rise starts cycle.
// - Every access moves exactly four data words.
// - Nibble selects sampled with their data word.
// - Nibble 0 is bits 3:0, 1 is 7:4.
// - Deselected nibble is ignored, stored nibble kept.
// - Byte lane enables sampled with their data word.
// - Lanes are nine bits wide, lower lanes first.
// - Deselected byte lane discarded, stored byte kept.
// - One address bus serves reads and writes.
// - Narrow organisations always start bursts at word zero.
// - Wide organisations load and linearly step burst counter.
// - Direction high means read, low means write.
// - Read data leaves on the output clock pair; on the reference pair in single mode.
// - Inputs captured on reference clock rise; both modes.
// - Accesses start only on the positive reference rise.
// - Write data also captured on negative reference rise.
// - Read drivers released when no read is active.
// - Echo clocks run freely with the output clock; with the reference clock in single mode.
`ifndef BSH_CONSTS_SVH
`define BSH_CONSTS_SVH

// ----------------------------------------------------------------------------
// Burst and lane layout
// ----------------------------------------------------------------------------
`define BSH_BEATS 3'h4
`define BSH_NO_BEATS 3'h0
`define BSH_BURST_ZERO 2'h0
`define BSH_BURST_STEP 2'h1
`define BSH_NIBBLE_W 4
`define BSH_BYTE_W 9
`define BSH_NIBBLE_LANES 2
`define BSH_LANE_PINS 4

// ----------------------------------------------------------------------------
// Controller spacing, in system clock cycles
// ----------------------------------------------------------------------------
`define BSH_GAP_AFTER_WRITE 3'h3
`define BSH_GAP_AFTER_READ 3'h5
`define BSH_GAP_NONE 3'h0
`define BSH_GAP_STEP 3'h1

`endif

// file: hw/bsh_ctrl.sv
// Memory controller end: makes the reference clocks and issues bursts.
`timescale 1ns/1ps
`include "bsh_consts.svh"
module bsh_ctrl #(
  parameter int PTR_W = 19,
  parameter int DW = 8
)(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  bsh_if.ctrl bus,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [PTR_W-1:0] req_ptr_i,
  input wire logic [1:0] req_burst_i,
  input wire logic [4*DW-1:0] req_wdata_i,
  input wire logic [15:0] req_lane_n_i,
  output logic req_ready_o,
  output logic [DW-1:0] rd_data_o,
  output logic rd_valid_o
);
  import bsh_pkg::*;

  if (!(DW == 8 || DW == 9 || DW == 18 || DW == 36))
  begin : g_bad_width
    $error("Unsupported data width.");
  end

  logic k, next_k, ld_n, next_ld_n, ready, next_ready, rd_valid, next_rd_valid;
  bsh_dir_t dir, next_dir;
  logic [PTR_W-1:0] ptr, next_ptr;
  logic [1:0] bs, next_bs;
  logic [4*DW-1:0] wbuf, next_wbuf;
  logic [15:0] lbuf, next_lbuf;
  logic [2:0] wcnt, next_wcnt, gap, next_gap;
  logic [DW-1:0] dq_d, next_dq_d, rd_data, next_rd_data;
  logic dq_oe, next_dq_oe;
  logic [3:0] lanes_n, next_lanes_n;
  logic [4:0] rsh, next_rsh;
  logic take;

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb
  begin
    take = req_valid_i && ready;
    next_k = ~k;
    next_ld_n = ~take;
    next_dir = take ? (req_write_i ? bsh_dir_write : bsh_dir_read) : dir;
    next_ptr = take ? req_ptr_i : ptr;
    next_bs = take ? req_burst_i : bs;
    next_wbuf = wbuf;
    next_lbuf = lbuf;
    next_wcnt = wcnt;
    next_dq_d = dq_d;
    next_lanes_n = '1;
    next_dq_oe = (wcnt != `BSH_NO_BEATS);
    if (wcnt != `BSH_NO_BEATS)
    begin
      next_dq_d = wbuf[DW-1:0];
      next_lanes_n = lbuf[3:0];
      next_wbuf = wbuf >> DW;
      next_lbuf = lbuf >> `BSH_LANE_PINS;
      next_wcnt = wcnt - `BSH_GAP_STEP;
    end
    if (take && req_write_i)
    begin
      next_wbuf = req_wdata_i;
      next_lbuf = req_lane_n_i;
      next_wcnt = `BSH_BEATS;
    end
    if (take)
    begin
      next_gap = req_write_i ? `BSH_GAP_AFTER_WRITE : `BSH_GAP_AFTER_READ;
    end
    else
    begin
      next_gap = (gap != `BSH_GAP_NONE) ? gap - `BSH_GAP_STEP : `BSH_GAP_NONE;
    end
    next_ready = !next_k && (next_gap == `BSH_GAP_NONE);
    next_rsh = {rsh[3:0], !ld_n && (dir == bsh_dir_read)};
    next_rd_valid = |rsh[4:1];
    next_rd_data = bus.dq;
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      k <= 1'b0;
      ld_n <= 1'b1;
      dir <= bsh_dir_write;
      ptr <= '0;
      bs <= `BSH_BURST_ZERO;
      wbuf <= '0;
      lbuf <= '1;
      wcnt <= `BSH_NO_BEATS;
      gap <= `BSH_GAP_NONE;
      dq_d <= '0;
      dq_oe <= 1'b0;
      lanes_n <= '1;
      ready <= 1'b0;
      rsh <= '0;
      rd_valid <= 1'b0;
      rd_data <= '0;
    end
    else
    begin
      k <= next_k;
      ld_n <= next_ld_n;
      dir <= next_dir;
      ptr <= next_ptr;
      bs <= next_bs;
      wbuf <= next_wbuf;
      lbuf <= next_lbuf;
      wcnt <= next_wcnt;
      gap <= next_gap;
      dq_d <= next_dq_d;
      dq_oe <= next_dq_oe;
      lanes_n <= next_lanes_n;
      ready <= next_ready;
      rsh <= next_rsh;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
    end
  end

  // --------------------------------------------------------------------------
  // Pins and user outputs
  // --------------------------------------------------------------------------
  assign bus.input_ref_pos = k;
  assign bus.input_ref_neg = ~k;
  assign bus.output_time_pos = k;
  assign bus.output_time_neg = ~k;
  assign bus.load_strobe_n = ld_n;
  assign bus.access_direction = dir;
  assign bus.pointer_bits = ptr;
  assign bus.burst_start_low = bs[0];
  assign bus.burst_start_high = bs[1];
  assign bus.nibble_write_select_n = lanes_n[1:0];
  assign bus.byte_lane_enable_n = lanes_n;
  assign bus.ctrl_d = dq_d;
  assign bus.ctrl_d_oe = dq_oe;
  assign req_ready_o = ready;
  assign rd_data_o = rd_data;
  assign rd_valid_o = rd_valid;

endmodule // bsh_ctrl

// file: hw/bsh_dev.sv
// Device end: command capture, burst counters, masked writes and read drive.
`timescale 1ns/1ps
`include "bsh_consts.svh"
module bsh_dev #(
  parameter int PTR_W = 19,
  parameter int DW = 8,
  parameter int AW = 10
)(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  bsh_if.dev bus,
  input wire logic single_clock_mode_i,
  output logic write_active_o,
  output logic read_active_o
);
  import bsh_pkg::*;

  localparam int LANES = (DW == 8) ? `BSH_NIBBLE_LANES : DW / `BSH_BYTE_W;
  localparam int LANE_W = (DW == 8) ? `BSH_NIBBLE_W : `BSH_BYTE_W;
  localparam int PW = AW - 2;

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  if (!(DW == 8 || DW == 9 || DW == 18 || DW == 36))
  begin : g_bad_width
    $error("Unsupported data width.");
  end
  if (AW < 3 || PW > PTR_W)
  begin : g_bad_depth
    $error("Array address width does not fit the pointer.");
  end

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic k_pos_q, next_k_pos_q, k_neg_q, next_k_neg_q;
  logic c_pos_q, next_c_pos_q, c_neg_q, next_c_neg_q;
  logic k_rise, kn_rise, c_rise, cn_rise, in_evt, out_evt;
  logic load, load_write, load_read;
  logic [1:0] start;
  logic [PW-1:0] w_ptr, next_w_ptr, r_ptr, next_r_ptr;
  logic [1:0] w_burst, next_w_burst, r_burst, next_r_burst;
  logic [2:0] w_cnt, next_w_cnt, r_cnt, next_r_cnt;
  logic [DW-1:0] q, next_q;
  logic q_oe, next_q_oe;
  logic echo_pos, next_echo_pos, echo_neg, next_echo_neg;
  logic we;
  logic [LANES-1:0] lane_en;
  logic [DW-1:0] rdata;
  bsh_dir_t dir_in;

  // --------------------------------------------------------------------------
  // Clock edge events
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_k_pos_q = bus.input_ref_pos;
    next_k_neg_q = bus.input_ref_neg;
    next_c_pos_q = bus.output_time_pos;
    next_c_neg_q = bus.output_time_neg;
    k_rise = bus.input_ref_pos && !k_pos_q;
    kn_rise = bus.input_ref_neg && !k_neg_q;
    c_rise = bus.output_time_pos && !c_pos_q;
    cn_rise = bus.output_time_neg && !c_neg_q;
    in_evt = k_rise || kn_rise;
    out_evt = single_clock_mode_i ? in_evt : (c_rise || cn_rise);
  end

  // --------------------------------------------------------------------------
  // Command capture
  // --------------------------------------------------------------------------
  always_comb
  begin
    dir_in = bsh_dir_t'(bus.access_direction);
    load = k_rise && !bus.load_strobe_n;
    load_write = load && (dir_in == bsh_dir_write);
    load_read = load && (dir_in == bsh_dir_read);
    if (DW >= 18)
    begin
      start = {bus.burst_start_high, bus.burst_start_low};
    end
    else
    begin
      start = `BSH_BURST_ZERO;
    end
  end

  // --------------------------------------------------------------------------
  // Write burst
  // --------------------------------------------------------------------------
  always_comb
  begin
    we = (w_cnt != `BSH_NO_BEATS) && in_evt;
    next_w_ptr = w_ptr;
    next_w_burst = w_burst;
    next_w_cnt = w_cnt;
    if (we)
    begin
      next_w_burst = w_burst + `BSH_BURST_STEP;
      next_w_cnt = w_cnt - `BSH_GAP_STEP;
    end
    if (load_write)
    begin
      next_w_ptr = bus.pointer_bits[PW-1:0];
      next_w_burst = start;
      next_w_cnt = `BSH_BEATS;
    end
  end

  if (DW == 8)
  begin : g_nibble
    assign lane_en = ~bus.nibble_write_select_n;
  end
  else
  begin : g_byte
    assign lane_en = ~bus.byte_lane_enable_n[LANES-1:0];
  end

  bsh_mem #(
    .AW(AW),
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) u_mem (
    .clk_sys_i(clk_sys_i),
    .we_i(we),
    .waddr_i({w_ptr, w_burst}),
    .wdata_i(bus.dq),
    .lane_en_i(lane_en),
    .raddr_i({r_ptr, r_burst}),
    .rdata_o(rdata)
  );

  // --------------------------------------------------------------------------
  // Read burst and output drivers
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_r_ptr = r_ptr;
    next_r_burst = r_burst;
    next_r_cnt = r_cnt;
    next_q = q;
    next_q_oe = q_oe;
    if (out_evt)
    begin
      next_q_oe = (r_cnt != `BSH_NO_BEATS);
      if (r_cnt != `BSH_NO_BEATS)
      begin
        next_q = rdata;
        next_r_burst = r_burst + `BSH_BURST_STEP;
        next_r_cnt = r_cnt - `BSH_GAP_STEP;
      end
    end
    if (load_read)
    begin
      next_r_ptr = bus.pointer_bits[PW-1:0];
      next_r_burst = start;
      next_r_cnt = `BSH_BEATS;
    end
  end

  // --------------------------------------------------------------------------
  // Echo clocks
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_echo_pos = single_clock_mode_i ? bus.input_ref_pos : bus.output_time_pos;
    next_echo_neg = ~next_echo_pos;
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      k_pos_q <= 1'b0;
      k_neg_q <= 1'b1;
      c_pos_q <= 1'b0;
      c_neg_q <= 1'b1;
      w_ptr <= '0;
      w_burst <= `BSH_BURST_ZERO;
      w_cnt <= `BSH_NO_BEATS;
      r_ptr <= '0;
      r_burst <= `BSH_BURST_ZERO;
      r_cnt <= `BSH_NO_BEATS;
      q <= '0;
      q_oe <= 1'b0;
      echo_pos <= 1'b0;
      echo_neg <= 1'b1;
      write_active_o <= 1'b0;
      read_active_o <= 1'b0;
    end
    else
    begin
      k_pos_q <= next_k_pos_q;
      k_neg_q <= next_k_neg_q;
      c_pos_q <= next_c_pos_q;
      c_neg_q <= next_c_neg_q;
      w_ptr <= next_w_ptr;
      w_burst <= next_w_burst;
      w_cnt <= next_w_cnt;
      r_ptr <= next_r_ptr;
      r_burst <= next_r_burst;
      r_cnt <= next_r_cnt;
      q <= next_q;
      q_oe <= next_q_oe;
      echo_pos <= next_echo_pos;
      echo_neg <= next_echo_neg;
      write_active_o <= (next_w_cnt != `BSH_NO_BEATS);
      read_active_o <= (next_r_cnt != `BSH_NO_BEATS);
    end
  end

  // --------------------------------------------------------------------------
  // Pins
  // --------------------------------------------------------------------------
  assign bus.dev_q = q;
  assign bus.dev_q_oe = q_oe;
  assign bus.echo_clock_pos = echo_pos;
  assign bus.echo_clock_neg = echo_neg;

endmodule // bsh_dev

// file: hw/bsh_if.sv
// Pin bundle between the memory controller and the burst SRAM.
`timescale 1ns/1ps
interface bsh_if #(
  parameter int PTR_W = 19,
  parameter int DW = 8
);
  logic input_ref_pos;
  logic input_ref_neg;
  logic output_time_pos;
  logic output_time_neg;
  logic echo_clock_pos;
  logic echo_clock_neg;
  logic load_strobe_n;
  logic access_direction;
  logic [PTR_W-1:0] pointer_bits;
  logic burst_start_low;
  logic burst_start_high;
  logic [1:0] nibble_write_select_n;
  logic [3:0] byte_lane_enable_n;
  logic [DW-1:0] ctrl_d;
  logic ctrl_d_oe;
  logic [DW-1:0] dev_q;
  logic dev_q_oe;
  logic [DW-1:0] dq;

  // Resolved level of the shared data wires.
  assign dq = dev_q_oe ? dev_q : (ctrl_d_oe ? ctrl_d : '0);

  modport ctrl (
    output input_ref_pos, input_ref_neg, output_time_pos, output_time_neg,
    output load_strobe_n, access_direction, pointer_bits, burst_start_low, burst_start_high,
    output nibble_write_select_n, byte_lane_enable_n, ctrl_d, ctrl_d_oe,
    input echo_clock_pos, echo_clock_neg, dq
  );

  modport dev (
    input input_ref_pos, input_ref_neg, output_time_pos, output_time_neg,
    input load_strobe_n, access_direction, pointer_bits, burst_start_low, burst_start_high,
    input nibble_write_select_n, byte_lane_enable_n, dq,
    output echo_clock_pos, echo_clock_neg, dev_q, dev_q_oe
  );
endinterface

// file: hw/bsh_mem.sv
// Lane-masked storage array used by the device end.
`timescale 1ns/1ps
module bsh_mem #(
  parameter int AW = 10,
  parameter int LANES = 2,
  parameter int LANE_W = 4
)(
  input wire logic clk_sys_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [LANES*LANE_W-1:0] wdata_i,
  input wire logic [LANES-1:0] lane_en_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [LANES*LANE_W-1:0] rdata_o
);

  if (AW < 1 || LANES < 1 || LANE_W < 1)
  begin : g_bad_shape
    $error("Unsupported array shape.");
  end

  // --------------------------------------------------------------------------
  // One array per lane, so a masked lane keeps its stored value.
  // --------------------------------------------------------------------------
  for (genvar l = 0; l < LANES; l++)
  begin : g_lane
    logic [LANE_W-1:0] cells [0:(1<<AW)-1];

    always_ff @(posedge clk_sys_i)
    begin
      if (we_i && lane_en_i[l])
      begin
        cells[waddr_i] <= wdata_i[l*LANE_W +: LANE_W];
      end
    end

    assign rdata_o[l*LANE_W +: LANE_W] = cells[raddr_i];
  end

endmodule // bsh_mem

// file: hw/bsh_pkg.sv
// Types shared by both ends of the burst SRAM host interface.
package bsh_pkg;

  typedef enum logic {bsh_dir_write, bsh_dir_read} bsh_dir_t;

endpackage

// file: testbench/bsh_chk.sv
// Concurrent checks on the pins between the controller end and the device end.
`timescale 1ns/1ps
module bsh_chk (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic input_ref_pos,
  input wire logic input_ref_neg,
  input wire logic output_time_pos,
  input wire logic echo_clock_pos,
  input wire logic echo_clock_neg,
  input wire logic load_strobe_n,
  input wire logic access_direction,
  input wire logic [1:0] nibble_write_select_n,
  input wire logic [3:0] byte_lane_enable_n,
  input wire logic ctrl_d_oe,
  input wire logic dev_q_oe
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  chk_load_on_rise: assert property (
    !load_strobe_n |-> input_ref_pos && !$past(input_ref_pos))
    else $error("load strobe outside a reference clock rise");
  chk_ref_clock_pair: assert property (
    $past(arst_n_i) |-> input_ref_pos != $past(input_ref_pos) && input_ref_neg == !input_ref_pos &&
    output_time_pos == input_ref_pos)
    else $error("reference clock pair does not toggle as a pair");
  chk_load_spacing: assert property (
    !load_strobe_n |=> load_strobe_n [*3])
    else $error("loads closer than two reference periods");
  chk_write_four_beats: assert property (
    !load_strobe_n && !access_direction |=> ctrl_d_oe [*4])
    else $error("write burst does not carry four beats");
  chk_masks_idle_high: assert property (
    !ctrl_d_oe |-> (&nibble_write_select_n) && (&byte_lane_enable_n))
    else $error("write selects active outside write beats");
  chk_read_drive: assert property (
    !load_strobe_n && access_direction |-> ##2 dev_q_oe [*4])
    else $error("read burst not driven for four beats");
  chk_read_release: assert property (
    !load_strobe_n && access_direction |-> ##6 !dev_q_oe)
    else $error("read drivers not released after the burst");
  chk_no_contention: assert property (
    dev_q_oe |-> !ctrl_d_oe)
    else $error("both ends drive the data wires");
  chk_echo_follow: assert property (
    echo_clock_pos == $past(output_time_pos) && echo_clock_neg == !echo_clock_pos)
    else $error("echo clocks do not follow the output clock");

  cov_write_load: cover property (!load_strobe_n && !access_direction);
  cov_read_load: cover property (!load_strobe_n && access_direction);
  cov_back_to_back: cover property (!load_strobe_n ##4 !load_strobe_n);
  cov_masked_beat: cover property (ctrl_d_oe && nibble_write_select_n != 2'h0);
endmodule // bsh_chk

// file: testbench/burst_sram_host_interface_tb.sv
// Self-checking bench: controller and device ends joined through the pin bundle.
`timescale 1ns/1ps
module burst_sram_host_interface_tb;
  typedef struct packed {logic wr; logic [18:0] ptr; logic [31:0] wdata; logic [15:0] lane_n;} bsh_row_t;
  logic clk_sys_i;
  logic arst_n_i;
  logic req_valid;
  logic req_write;
  logic req_ready;
  logic rd_valid;
  logic single_mode;
  logic [18:0] req_ptr;
  logic [1:0] req_burst;
  logic [31:0] req_wdata;
  logic [15:0] req_lane_n;
  logic [7:0] rd_data;
  logic wr_act;
  logic rd_act;
  int wr_left;
  int rd_left;
  logic [7:0] model [1024];
  logic [7:0] exp_rd [$];
  logic [13:0] exp_wire [$];
  int miscompares;
  int check_count;
  bsh_row_t rows [8];

  bsh_if bus_if ();
  bsh_ctrl bsh_ctrl_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .bus(bus_if), .req_valid_i(req_valid),
    .req_write_i(req_write), .req_ptr_i(req_ptr), .req_burst_i(req_burst), .req_wdata_i(req_wdata),
    .req_lane_n_i(req_lane_n), .req_ready_o(req_ready), .rd_data_o(rd_data), .rd_valid_o(rd_valid));
  bsh_dev bsh_dev_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .bus(bus_if), .single_clock_mode_i(single_mode),
    .write_active_o(wr_act), .read_active_o(rd_act));
  bsh_chk bsh_chk_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .input_ref_pos(bus_if.input_ref_pos),
    .input_ref_neg(bus_if.input_ref_neg), .output_time_pos(bus_if.output_time_pos),
    .echo_clock_pos(bus_if.echo_clock_pos), .echo_clock_neg(bus_if.echo_clock_neg),
    .load_strobe_n(bus_if.load_strobe_n), .access_direction(bus_if.access_direction),
    .nibble_write_select_n(bus_if.nibble_write_select_n), .byte_lane_enable_n(bus_if.byte_lane_enable_n),
    .ctrl_d_oe(bus_if.ctrl_d_oe), .dev_q_oe(bus_if.dev_q_oe));

  // ---------------------------------------------------------------------------
  // Comparison and closing tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    check_count++;
    if (seen !== expd)
    begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks made %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Request driver with reference model
  // ---------------------------------------------------------------------------
  task automatic do_req(input bsh_row_t r);
    int n;
    logic [9:0] idx;
    logic [3:0] m;
    req_valid = 1'b1;
    req_write = r.wr;
    req_ptr = r.ptr;
    req_burst = r.ptr[1:0];
    req_wdata = r.wdata;
    req_lane_n = r.lane_n;
    for (int b = 0; b < 4; b++)
    begin
      idx = {r.ptr[7:0], 2'(b)};
      m = r.lane_n[4*b+:4];
      if (!r.wr)
        exp_rd.push_back(model[idx]);
      else
      begin
        if (!m[0])
          model[idx][3:0] = r.wdata[8*b+:4];
        if (!m[1])
          model[idx][7:4] = r.wdata[8*b+4+:4];
        exp_wire.push_back({m[1:0], m, r.wdata[8*b+:8]});
      end
    end
    n = 0;
    while (req_ready !== 1'b1 && n < 50)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n >= 50)
    begin
      miscompares++;
      tally_and_finish();
    end
    @(negedge clk_sys_i);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_rd.size() + exp_wire.size() != 0 && n < 60)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    check(32'(exp_rd.size() + exp_wire.size()), 32'h0);
  endtask

  // ---------------------------------------------------------------------------
  // Monitors of read words and of write beats on the wires
  // ---------------------------------------------------------------------------
  always @(negedge clk_sys_i)
  begin
    if (rd_valid === 1'b1)
    begin
      if (exp_rd.size() == 0)
        check(32'(rd_data), 32'hx);
      else
        check(32'(rd_data), 32'(exp_rd.pop_front()));
    end
    if (bus_if.ctrl_d_oe === 1'b1)
    begin
      if (exp_wire.size() == 0)
        check(32'(bus_if.dq), 32'hx);
      else
        check(32'({bus_if.nibble_write_select_n, bus_if.byte_lane_enable_n, bus_if.dq}),
          32'(exp_wire.pop_front()));
    end
  end

  // Burst activity flags of the device end: four beats after each load.
  always @(negedge clk_sys_i)
  begin
    if (arst_n_i !== 1'b1)
    begin
      wr_left = 0;
      rd_left = 0;
    end
    else
    begin
      check(32'(wr_act), 32'(wr_left != 0));
      check(32'(rd_act), 32'(rd_left != 0));
      if (bus_if.load_strobe_n === 1'b0 && bus_if.access_direction === 1'b0)
        wr_left = 4;
      else if (wr_left > 0)
        wr_left--;
      if (bus_if.load_strobe_n === 1'b0 && bus_if.access_direction === 1'b1)
        rd_left = 4;
      else if (rd_left > 0)
        rd_left--;
    end
  end

  initial
  begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    miscompares = 0;
    check_count = 0;
    arst_n_i = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_ptr = 19'h0;
    req_burst = 2'h0;
    req_wdata = 32'h0;
    req_lane_n = 16'hffff;
    single_mode = 1'b0;
    rows[0] = '{1'b1, 19'h00005, 32'h44332211, 16'h0000};
    rows[1] = '{1'b1, 19'h000a3, 32'hddccbbaa, 16'h0000};
    rows[2] = '{1'b0, 19'h00005, 32'h0, 16'hffff};
    rows[3] = '{1'b1, 19'h00005, 32'hffeeddcc, 16'h3210};
    rows[4] = '{1'b0, 19'h00005, 32'h0, 16'hffff};
    rows[5] = '{1'b0, 19'h000a3, 32'h0, 16'hffff};
    rows[6] = '{1'b1, 19'h40105, 32'h87654321, 16'hf000};
    rows[7] = '{1'b0, 19'h00005, 32'h0, 16'hffff};
    repeat (6) @(negedge clk_sys_i);
    check(32'({bus_if.load_strobe_n, bus_if.dev_q_oe, bus_if.ctrl_d_oe, req_ready, bus_if.echo_clock_pos,
      bus_if.echo_clock_neg}), 32'h21);
    arst_n_i = 1'b1;
    for (int md = 0; md < 2; md++)
    begin
      single_mode = md[0];
      foreach (rows[i])
        do_req(rows[i]);
      req_valid = 1'b0;
      drain();
    end
    do_req(rows[5]);
    req_valid = 1'b0;
    @(negedge clk_sys_i);
    arst_n_i = 1'b0;
    exp_rd.delete();
    @(negedge clk_sys_i);
    check(32'({bus_if.load_strobe_n, bus_if.dev_q_oe, rd_valid, req_ready, bus_if.input_ref_pos}), 32'h10);
    @(negedge clk_sys_i);
    arst_n_i = 1'b1;
    @(negedge clk_sys_i);
    check(32'({bus_if.input_ref_pos, req_ready}), 32'h2);
    @(negedge clk_sys_i);
    check(32'({bus_if.input_ref_pos, req_ready}), 32'h1);
    do_req(rows[1]);
    do_req(rows[5]);
    req_valid = 1'b0;
    drain();
    tally_and_finish();
  end
endmodule // burst_sram_host_interface_tb
